/* File: verilog/itsf_filter.sv */
// What this block does
// - 48-tap FIR per channel, no feedback
// - symbols in at 600 Hz, samples 9.6 kHz
// - new symbol every 16 samples, else zero
// - three multiply-accumulates per output sample
// - history shifts only when symbol accepted
// - otherwise history holds, coefficient phase advances
// - oldest at highest index, newest lowest
// - exactly three past values per channel
// - output is sum of products, cleared first
// - root raised-cosine coefficients, 300 Hz, 0.75
// - response falls to about -40 dB at 600 Hz
// - 37 nonzero taps padded to 48
// - identical separate I and Q filters
// - non-symbol samples accumulate without moving history
`timescale 1ns/10ps
`default_nettype none
module itsf_filter
  import itsf_pkg::*;
#(
  parameter int unsigned SAMPLE_DIVIDE = itsf_pkg::SAMPLE_DIV
)
(
  // clock and reset
  input wire logic clk_sys,
  input wire logic sys_rst,
  // symbol pair from encoder
  input wire logic sym_valid,
  input wire itsf_pkg::itsf_pair_type sym_in,
  output logic sym_ready,
  // filtered sample pair to modulator
  output logic out_valid,
  output itsf_pkg::itsf_pair_type out_data,
  input wire logic out_ready
);
  import itsf_pkg::*;

  // sampled root raised-cosine, centred on tap 18, zero padded
  function automatic logic signed [COEF_W-1:0] coef_lookup(input logic [TAP_W-1:0] tap);
    logic signed [COEF_W-1:0] c;
    c = 16'h0000;
    unique case (tap)
      6'h00: c = 16'hFB85;
      6'h01: c = 16'hFB48;
      6'h02: c = 16'hFB85;
      6'h03: c = 16'hFC55;
      6'h04: c = 16'hFDCE;
      6'h05: c = 16'hFFFD;
      6'h06: c = 16'h02E4;
      6'h07: c = 16'h067A;
      6'h08: c = 16'h0AAB;
      6'h09: c = 16'h0F59;
      6'h0A: c = 16'h145A;
      6'h0B: c = 16'h197F;
      6'h0C: c = 16'h1E8F;
      6'h0D: c = 16'h2356;
      6'h0E: c = 16'h2795;
      6'h0F: c = 16'h2B20;
      6'h10: c = 16'h2DCA;
      6'h11: c = 16'h2F70;
      6'h12: c = 16'h3000;
      6'h13: c = 16'h2F70;
      6'h14: c = 16'h2DCA;
      6'h15: c = 16'h2B20;
      6'h16: c = 16'h2795;
      6'h17: c = 16'h2356;
      6'h18: c = 16'h1E8F;
      6'h19: c = 16'h197F;
      6'h1A: c = 16'h145A;
      6'h1B: c = 16'h0F59;
      6'h1C: c = 16'h0AAB;
      6'h1D: c = 16'h067A;
      6'h1E: c = 16'h02E4;
      6'h1F: c = 16'hFFFD;
      6'h20: c = 16'hFDCE;
      6'h21: c = 16'hFC55;
      6'h22: c = 16'hFB85;
      6'h23: c = 16'hFB48;
      6'h24: c = 16'hFB85;
      // taps 37..47 are the padding
      default: c = 16'h0000;
    endcase
    return c;
  endfunction

  // both channels share one product shape
  function automatic logic signed [ACC_W-1:0] mac_term(
    input logic signed [DATA_W-1:0] x,
    input logic signed [COEF_W-1:0] c
  );
    logic signed [DATA_W+COEF_W-1:0] p;
    p = x * c;
    return ACC_W'(p);
  endfunction

  // drop fraction bits and clamp instead of wrapping
  function automatic logic signed [DATA_W-1:0] scale_sat(input logic signed [ACC_W-1:0] a);
    logic signed [ACC_W-1:0] s;
    logic signed [DATA_W-1:0] r;
    s = a >>> FRAC_SHIFT;
    r = s[DATA_W-1:0];
    if (s > ACC_W'($signed({1'b0, {(DATA_W-1){1'b1}}})))
      r = {1'b0, {(DATA_W-1){1'b1}}};
    else if (s < ACC_W'($signed({1'b1, {(DATA_W-1){1'b0}}})))
      r = {1'b1, {(DATA_W-1){1'b0}}};
    return r;
  endfunction

  // three-way slot select, slot 0 is the newest symbol
  function automatic logic signed [DATA_W-1:0] pick_slot(input logic [SLOT_W-1:0] sel,
    input logic signed [DATA_W-1:0] v0, v1, v2);
    logic signed [DATA_W-1:0] r;
    r = v0;
    if (sel == SLOT_OLDEST)
      r = v2;
    else if (sel == 2'h1)
      r = v1;
    return r;
  endfunction

  // sample strobe divider
  logic [DIV_W-1:0] div_q;
  logic sample_tick;
  logic tick_pend_q;

  // filter state
  itsf_state_type state_q;
  logic [PHASE_W-1:0] coef_phase_pointer;
  logic [SLOT_W-1:0] slot_q;
  logic signed [DATA_W-1:0] hist_i_q [HIST_LEN];
  logic signed [DATA_W-1:0] hist_q_q [HIST_LEN];
  logic signed [ACC_W-1:0] acc_i_q;
  logic signed [ACC_W-1:0] acc_q_q;
  logic sym_ready_q;
  logic sym_take;
  logic start_sample;

  // product terms of the current slot
  logic signed [COEF_W-1:0] coef_cur;
  logic signed [ACC_W-1:0] term_i;
  logic signed [ACC_W-1:0] term_q;

  // two-entry output buffer
  itsf_pair_type buf_head_q;
  itsf_pair_type buf_tail_q;
  logic [1:0] buf_count_q;
  logic buf_room;
  logic buf_push;
  logic buf_pop;
  logic out_valid_q;
  itsf_pair_type push_pair;

  // named views of the history slots, coefficient slots, result and phase flag
  logic signed [DATA_W-1:0] i_history_newest;
  logic signed [DATA_W-1:0] i_history_middle;
  logic signed [DATA_W-1:0] i_history_oldest;
  logic signed [COEF_W-1:0] coef_slot_zero;
  logic signed [COEF_W-1:0] coef_slot_one;
  logic signed [COEF_W-1:0] coef_slot_two;
  logic signed [DATA_W-1:0] i_filter_result;
  logic load_accumulate_noshift;

  assign i_history_newest = hist_i_q[0];
  assign i_history_middle = hist_i_q[1];
  assign i_history_oldest = hist_i_q[2];

  // 9.6 kHz strobe from the 20 MHz clock
  assign sample_tick = (div_q == DIV_W'(SAMPLE_DIVIDE - 1));

  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
      div_q <= '0;
    else if (sample_tick)
      div_q <= '0;
    else
      div_q <= div_q + 1'b1;
  end

  // one tick is remembered while the buffer stalls us; more are dropped
  assign start_sample = (state_q == ST_IDLE) && tick_pend_q;

  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
      tick_pend_q <= 1'b0;
    else if (sample_tick)
      tick_pend_q <= 1'b1;
    else if (start_sample)
      tick_pend_q <= 1'b0;
  end

  // symbol handshake, only on phase zero
  assign sym_take = sym_ready_q && sym_valid;
  assign load_accumulate_noshift = (coef_phase_pointer != PHASE_RESET);

  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
      sym_ready_q <= 1'b0;
    else if (start_sample && !load_accumulate_noshift)
      sym_ready_q <= 1'b1;
    else if (sym_take)
      sym_ready_q <= 1'b0;
  end

  // sequencer: idle, take symbol, three MAC slots, push result
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
      state_q <= ST_IDLE;
    else
    begin
      unique case (state_q)
        ST_IDLE:
          if (start_sample)
            state_q <= load_accumulate_noshift ? ST_MAC : ST_SYMBOL;
        ST_SYMBOL:
          if (sym_take)
            state_q <= ST_MAC;
        ST_MAC:
          if (slot_q == SLOT_NEWEST)
            state_q <= ST_PUSH;
        ST_PUSH:
          if (buf_room)
            state_q <= ST_IDLE;
      endcase
    end
  end

  // slot walks oldest to newest, one product per clock
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
      slot_q <= SLOT_OLDEST;
    else if (state_q == ST_MAC)
      slot_q <= (slot_q == SLOT_NEWEST) ? SLOT_OLDEST : slot_q - 1'b1;
    else
      slot_q <= SLOT_OLDEST;
  end

  // history: index 0 newest, 2 oldest; moves only on an accepted symbol
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      for (int k = 0; k < HIST_LEN; k++)
      begin
        hist_i_q[k] <= '0;
        hist_q_q[k] <= '0;
      end
    end
    else if (sym_take)
    begin
      for (int k = HIST_LEN - 1; k > 0; k--)
      begin
        hist_i_q[k] <= hist_i_q[k-1];
        hist_q_q[k] <= hist_q_q[k-1];
      end
      hist_i_q[0] <= sym_in.i;
      hist_q_q[0] <= sym_in.q;
    end
  end

  // coefficient phase rotates once per output sample instead of data
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
      coef_phase_pointer <= PHASE_RESET;
    else if (state_q == ST_PUSH && buf_room)
      coef_phase_pointer <= coef_phase_pointer + 1'b1;
  end

  // tap index = slot*16 + phase; zero-stuffed inputs never multiply
  assign coef_slot_zero = coef_lookup({SLOT_NEWEST, coef_phase_pointer});
  assign coef_slot_one = coef_lookup({2'h1, coef_phase_pointer});
  assign coef_slot_two = coef_lookup({SLOT_OLDEST, coef_phase_pointer});
  assign coef_cur = pick_slot(slot_q, coef_slot_zero, coef_slot_one, coef_slot_two);
  assign term_i = mac_term(pick_slot(slot_q, i_history_newest, i_history_middle,
    i_history_oldest), coef_cur);
  assign term_q = mac_term(pick_slot(slot_q, hist_q_q[0], hist_q_q[1], hist_q_q[2]), coef_cur);

  // accumulators, pure feed-forward
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      acc_i_q <= '0;
      acc_q_q <= '0;
    end
    else if (state_q == ST_MAC && slot_q == SLOT_OLDEST)
    begin
      acc_i_q <= term_i;
      acc_q_q <= term_q;
    end
    else if (state_q == ST_MAC)
    begin
      acc_i_q <= acc_i_q + term_i;
      acc_q_q <= acc_q_q + term_q;
    end
  end

  assign i_filter_result = scale_sat(acc_i_q);
  assign push_pair.i = i_filter_result;
  assign push_pair.q = scale_sat(acc_q_q);

  // buffer: a modulator stall holds the sequencer in push
  assign buf_room = (buf_count_q != BUF_DEPTH);
  assign buf_push = (state_q == ST_PUSH) && buf_room;
  assign buf_pop = out_valid_q && out_ready;

  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
      buf_count_q <= 2'h0;
    else if (buf_push && !buf_pop)
      buf_count_q <= buf_count_q + 1'b1;
    else if (buf_pop && !buf_push)
      buf_count_q <= buf_count_q - 1'b1;
  end

  // head always holds the oldest entry so out_data is a flop
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      buf_head_q <= '0;
      buf_tail_q <= '0;
    end
    else
    begin
      if (buf_pop)
      begin
        if (buf_count_q == 2'h2)
          buf_head_q <= buf_tail_q;
        else if (buf_push)
          buf_head_q <= push_pair;
      end
      else if (buf_push && buf_count_q == 2'h0)
        buf_head_q <= push_pair;
      if (buf_push && ((buf_count_q == 2'h1 && !buf_pop) || buf_count_q == 2'h2))
        buf_tail_q <= push_pair;
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
      out_valid_q <= 1'b0;
    else if (buf_push)
      out_valid_q <= 1'b1;
    else if (buf_pop && buf_count_q == 2'h1)
      out_valid_q <= 1'b0;
  end

  assign sym_ready = sym_ready_q;
  assign out_valid = out_valid_q;
  assign out_data = buf_head_q;

endmodule // itsf_filter
`default_nettype wire

/* File: verilog/itsf_pkg.sv */
`default_nettype none
package itsf_pkg;

  // rates and derived counts
  localparam int unsigned CLK_HZ = 20_000_000;
  localparam int unsigned SAMPLE_HZ = 9_600;
  localparam int unsigned SYMBOL_HZ = 600;
  localparam int unsigned INTERP = SAMPLE_HZ / SYMBOL_HZ;
  // integer division: sample period is 2083 clocks, 9601.5 Hz actual
  localparam int unsigned SAMPLE_DIV = CLK_HZ / SAMPLE_HZ;
  localparam int unsigned DIV_W = 12;

  // filter shape
  localparam int unsigned TAPS = 48;
  localparam int unsigned NONZERO_TAPS = 37;
  localparam int unsigned HIST_LEN = TAPS / INTERP;
  localparam int unsigned PHASE_W = 4;
  localparam int unsigned SLOT_W = 2;
  localparam int unsigned TAP_W = PHASE_W + SLOT_W;

  // data widths, coefficient fraction bits
  localparam int unsigned DATA_W = 16;
  localparam int unsigned COEF_W = 16;
  localparam int unsigned ACC_W = 34;
  localparam int unsigned FRAC_SHIFT = 15;

  // reset values, slot ends and buffer depth
  localparam logic [PHASE_W-1:0] PHASE_RESET = 4'h0;
  localparam logic [SLOT_W-1:0] SLOT_OLDEST = 2'h2;
  localparam logic [SLOT_W-1:0] SLOT_NEWEST = 2'h0;
  localparam logic [1:0] BUF_DEPTH = 2'h2;

  typedef struct packed {
    logic signed [DATA_W-1:0] i;
    logic signed [DATA_W-1:0] q;
  } itsf_pair_type;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_SYMBOL,
    ST_MAC,
    ST_PUSH
  } itsf_state_type;

endpackage
`default_nettype wire

/* File: bench/itsf_checker.sv */
`timescale 1ns/10ps
`default_nettype none
module itsf_checker
  import itsf_pkg::*;
#(
  parameter int unsigned SAMPLE_DIVIDE = 20
)
(
  // clock and reset
  input wire logic clk_sys,
  input wire logic sys_rst,
  // symbol side
  input wire logic sym_valid,
  input wire itsf_pkg::itsf_pair_type sym_in,
  input wire logic sym_ready,
  // sample side
  input wire logic out_valid,
  input wire itsf_pkg::itsf_pair_type out_data,
  input wire logic out_ready
);
  logic take;
  logic seen_q;
  logic [15:0] gap_q;
  logic [4:0] pop_q;
  assign take = sym_valid && sym_ready;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (sys_rst);
  // saturating, so a long idle spell cannot wrap into a false short gap
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst || take)
      gap_q <= 16'h0000;
    else if (gap_q != 16'hFFFF)
      gap_q <= gap_q + 16'h0001;
  end
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst || take)
      pop_q <= 5'h00;
    else if (out_valid && out_ready && pop_q != 5'h1F)
      pop_q <= pop_q + 5'h01;
  end
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
      seen_q <= 1'b0;
    else if (take)
      seen_q <= 1'b1;
  end
  hold_out_a: assert property (out_valid && !out_ready |=> out_valid && $stable(out_data))
    else $error("output word moved while stalled");
  one_take_a: assert property (take |=> !sym_ready)
    else $error("symbol port still open after a take");
  take_gap_a: assert property (take && seen_q |-> gap_q >= 14 * SAMPLE_DIVIDE)
    else $error("symbols taken too close together");
  pop_count_a: assert property (take && seen_q |-> pop_q >= 13 && pop_q <= 19)
    else $error("wrong sample count between symbols");
  rst_clear_a: assert property ($fell(sys_rst) |-> !out_valid && !sym_ready && out_data == '0)
    else $error("outputs not cleared by reset");
  quiet_start_a: assert property ($fell(sys_rst) |-> !sym_ready [*8])
    else $error("symbol wanted before the first tick");
  out_soon_a: assert property (take |-> ##[1:10] out_valid)
    else $error("no sample soon after a symbol");
  ready_stands_a: assert property (sym_ready && !sym_valid |=> sym_ready)
    else $error("symbol request withdrawn");
endmodule // itsf_checker
`default_nettype wire

/* File: bench/itsf_partner.sv */
`timescale 1ns/10ps
`default_nettype none
module itsf_partner
  import itsf_pkg::*;
(
  // clock and reset
  input wire logic clk_sys,
  input wire logic sys_rst,
  // behaviour knobs
  input wire logic slow,
  input wire logic stall,
  // encoder side
  output logic sym_valid,
  output itsf_pkg::itsf_pair_type sym_in,
  input wire logic sym_ready,
  // modulator side
  input wire logic out_valid,
  input wire itsf_pkg::itsf_pair_type out_data,
  output logic out_ready
);
  itsf_pair_type q[$];
  itsf_pair_type got[$];
  // released bus shows the inverted word so stale data never matches
  always @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      sym_valid <= 1'b0;
      sym_in <= '0;
    end
    else if (sym_valid && sym_ready)
    begin
      sym_valid <= 1'b0;
      sym_in <= ~sym_in;
    end
    else if (!sym_valid && q.size() != 0 && !(slow && $urandom_range(3) == 0))
    begin
      sym_valid <= 1'b1;
      sym_in <= q.pop_front();
    end
  end
  always @(posedge clk_sys)
  begin
    if (out_valid && out_ready)
      got.push_back(out_data);
    out_ready <= !sys_rst && !stall && $urandom_range(7) != 0;
  end
endmodule // itsf_partner
`default_nettype wire

/* File: bench/test_itsf_filter.sv */
`timescale 1ns/10ps
`default_nettype none
module test_itsf_filter;
  import itsf_pkg::*;
  localparam int unsigned SD = 20;
  localparam logic signed [15:0] AMP = 16'h7FFF;
  logic clk_sys;
  logic sys_rst;
  logic slow;
  logic stall;
  logic sym_valid;
  logic sym_ready;
  logic out_valid;
  logic out_ready;
  logic [15:0] s;
  itsf_pair_type sym_in;
  itsf_pair_type out_data;
  itsf_pair_type ref_h[64];
  logic signed [15:0] sym_log[24];
  int err_count;
  int samples_checked;
  itsf_filter #(.SAMPLE_DIVIDE(SD)) i_itsf_filter (.clk_sys(clk_sys), .sys_rst(sys_rst),
    .sym_valid(sym_valid), .sym_in(sym_in), .sym_ready(sym_ready), .out_valid(out_valid),
    .out_data(out_data), .out_ready(out_ready));
  itsf_partner i_itsf_partner (.clk_sys(clk_sys), .sys_rst(sys_rst), .slow(slow),
    .stall(stall), .sym_valid(sym_valid), .sym_in(sym_in), .sym_ready(sym_ready),
    .out_valid(out_valid), .out_data(out_data), .out_ready(out_ready));
  initial
  begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end
  function automatic int mirror(input int k);
    return 36 - k;
  endfunction
  // sampled root raised-cosine, mirrored about tap 18, zero past tap 36
  function automatic logic signed [15:0] ref_coef(input int k);
    logic signed [15:0] c;
    c = 16'h0000;
    case (k > 18 ? mirror(k) : k)
      0: c = 16'hFB85;
      1: c = 16'hFB48;
      2: c = 16'hFB85;
      3: c = 16'hFC55;
      4: c = 16'hFDCE;
      5: c = 16'hFFFD;
      6: c = 16'h02E4;
      7: c = 16'h067A;
      8: c = 16'h0AAB;
      9: c = 16'h0F59;
      10: c = 16'h145A;
      11: c = 16'h197F;
      12: c = 16'h1E8F;
      13: c = 16'h2356;
      14: c = 16'h2795;
      15: c = 16'h2B20;
      16: c = 16'h2DCA;
      17: c = 16'h2F70;
      18: c = 16'h3000;
      default: c = 16'h0000;
    endcase
    return c;
  endfunction
  // output k: newest symbol k/16 at phase k%16, two older symbols behind it
  function automatic logic signed [15:0] ref_at(input int k);
    longint acc;
    acc = 64'sh0;
    for (int d = 0; d < 3; d++)
      if (k / 16 - d >= 0)
        acc += sym_log[k / 16 - d] * ref_coef(16 * d + k % 16);
    acc = acc >>> 15;
    if (acc > 64'sh7FFF)
      acc = 64'sh7FFF;
    else if (acc < -64'sh8000)
      acc = -64'sh8000;
    return 16'(acc);
  endfunction
  task automatic chk(input bit ok, input string msg);
    samples_checked++;
    if (!ok)
    begin
      err_count++;
      $display("CHECK FAILED at %0t: %s", $time, msg);
    end
  endtask
  task automatic give_verdict;
    $display("checks %0d, mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic wait_got(input int n);
    int t;
    t = 0;
    while (i_itsf_partner.got.size() < n && t < 30000)
    begin
      @(posedge clk_sys);
      t++;
    end
    chk(t < 30000, "no output progress");
  endtask
  // one symbol then silence; a long stall fills the buffer mid-response
  task automatic impulse;
    foreach (sym_log[k])
      sym_log[k] = 16'h0000;
    sym_log[0] = AMP;
    i_itsf_partner.q.push_back({AMP, AMP});
    repeat (4) i_itsf_partner.q.push_back('0);
    wait_got(10);
    stall <= 1'b1;
    repeat (5 * SD) @(posedge clk_sys);
    stall <= 1'b0;
    wait_got(80);
    for (int k = 0; k < 80; k++)
      chk(i_itsf_partner.got[k] === {ref_at(k), ref_at(k)}, "bad impulse");
  endtask
  initial
  begin
    sys_rst = 1'b1;
    slow = 1'b0;
    stall = 1'b0;
    void'($urandom(91));
    repeat (8) @(posedge clk_sys);
    sys_rst <= 1'b0;
    impulse();
    for (int k = 0; k < 64; k++)
      ref_h[k] = i_itsf_partner.got[k];
    for (int k = 0; k < 64; k++)
    begin
      chk(ref_h[k].i === ref_h[k].q, "channels differ");
      if (k < 18)
        chk(ref_h[k].i === ref_h[mirror(k)].i, "response not symmetric");
      if (k > 36)
        chk(ref_h[k] === '0, "tail not zero");
    end
    chk(ref_h[18].i > 0 && ref_h[18].i > ref_h[0].i, "no peak at centre");
    slow <= 1'b1;
    i_itsf_partner.got.delete();
    i_itsf_partner.q.push_back({16'h8000, 16'h8000});
    sym_log[0] = 16'h8000;
    for (int n = 0; n < 20; n++)
    begin
      s = 16'($urandom);
      sym_log[n + 1] = s;
      i_itsf_partner.q.push_back({s, s});
    end
    wait_got(300);
    foreach (i_itsf_partner.got[k])
    begin
      chk(i_itsf_partner.got[k].i === i_itsf_partner.got[k].q, "channels differ");
      chk(i_itsf_partner.got[k] === {ref_at(k), ref_at(k)}, "bad stream");
    end
    sys_rst <= 1'b1;
    repeat (8) @(posedge clk_sys);
    i_itsf_partner.q.delete();
    i_itsf_partner.got.delete();
    sys_rst <= 1'b0;
    slow <= 1'b0;
    impulse();
    for (int k = 0; k < 64; k++)
      chk(i_itsf_partner.got[k] === ref_h[k], "response after reset differs");
    give_verdict();
  end
  initial
  begin
    repeat (40000) @(posedge clk_sys);
    err_count++;
    give_verdict();
  end
endmodule // test_itsf_filter
bind itsf_filter itsf_checker #(.SAMPLE_DIVIDE(SAMPLE_DIVIDE)) i_itsf_checker (
  .clk_sys(clk_sys), .sys_rst(sys_rst), .sym_valid(sym_valid), .sym_in(sym_in),
  .sym_ready(sym_ready), .out_valid(out_valid), .out_data(out_data), .out_ready(out_ready));
`default_nettype wire
